//--- acqs_regs.svh
// Register offsets, field positions, reset values and clock rates of the acquisition block
`ifndef ACQS_REGS_SVH
`define ACQS_REGS_SVH

`define ACQS_ADDR_W 8
`define ACQS_OFF_CTRL 8'h00
`define ACQS_OFF_STATUS 8'h04
`define ACQS_OFF_RECLEN 8'h08
`define ACQS_OFF_PKTLEN 8'h0c
`define ACQS_OFF_DECIM 8'h10
`define ACQS_OFF_RECNUM 8'h14
`define ACQS_OFF_TSLO 8'h18
`define ACQS_OFF_OVFCNT 8'h1c
`define ACQS_OFF_NCO_BASE 8'h40
`define ACQS_NCO_STRIDE 8'h08

// Control fields
`define ACQS_CTRL_START 0
`define ACQS_CTRL_STOP 1
`define ACQS_CTRL_TRIGD 2
`define ACQS_CTRL_LOCK 3
`define ACQS_CTRL_ARM_SYNC 4
`define ACQS_CTRL_TRIG_AS_SYNC 5
`define ACQS_CTRL_REF_INT 6

// Status fields
`define ACQS_ST_RUN 0
`define ACQS_ST_WAIT_SYNC 1
`define ACQS_ST_SYNCED 2
`define ACQS_ST_CAPT 3
`define ACQS_ST_FULL 4

// Reset values
`define ACQS_RECLEN_RST 32'h0000_0400
`define ACQS_PKTLEN_RST 32'h0000_0100
`define ACQS_DECIM_RST 32'h0000_0000

// Reference clock rate and sampling clock rate
`define ACQS_REF_HZ 10000000
`define ACQS_CLK_HZ 250000000

`endif

//--- acqs_pkg.sv
// Types shared by the acquisition block
package acqs_pkg;
	typedef enum logic [3:0] {
		ACQS_IDLE = 4'b0001,
		ACQS_WAIT_TRIG = 4'b0010,
		ACQS_HEADER = 4'b0100,
		ACQS_CAPTURE = 4'b1000
	} acqs_state_t;

	typedef enum logic [1:0] {
		ACQS_W_DATA = 2'b00,
		ACQS_W_HDR_TS = 2'b01,
		ACQS_W_HDR_NUM = 2'b10
	} acqs_word_t;
endpackage : acqs_pkg

//--- acqs_fifo.sv
// Word FIFO standing in for the deep on-board buffer between capture and host link
module acqs_fifo #(
	parameter int WIDTH = 34,
	parameter int DEPTH_LOG2 = 6
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int DEPTH = 1 << DEPTH_LOG2;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [DEPTH_LOG2:0] wr_ptr;
	logic [DEPTH_LOG2:0] rd_ptr;
	wire do_wr = in_valid && in_ready;
	wire do_rd = out_valid && out_ready;

	// Full when pointers differ only in the wrap bit
	assign in_ready = (wr_ptr[DEPTH_LOG2] == rd_ptr[DEPTH_LOG2]) ||
		(wr_ptr[DEPTH_LOG2-1:0] != rd_ptr[DEPTH_LOG2-1:0]);
	assign out_valid = (wr_ptr != rd_ptr);
	assign out_data = mem[rd_ptr[DEPTH_LOG2-1:0]];

	// Storage write
	always_ff @(posedge pclk) begin
		if (do_wr) begin
			mem[wr_ptr[DEPTH_LOG2-1:0]] <= in_data;
		end
	end

	// Pointers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_wr) wr_ptr <= wr_ptr + 1'b1;
			if (do_rd) rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule : acqs_fifo

//--- acqs_ctrl.sv
// Acquisition control: streaming modes, record headers, sync strobe, oscillator setup
//
// How it works
// - continuous mode streams every sample from the first accepted trigger until software stop.
// - triggered mode captures one record of configured length per accepted trigger.
// - each triggered record starts with header words: trigger time-stamp, record number.
// - output words pass a first-in first-out buffer before the host link.
// - decimation is a power of two, stored as an exponent; only channel 0 is writable.
// - each I or Q sample occupies two bytes of the output word.
// - oscillators lock to a 10 MHz reference, external or internal.
// - when armed, oscillators align on the first reference edge after the strobe.
// - the same strobe event clears the time-stamp counter.
// - a control bit lets the trigger input serve as sync strobe.
// - each channel has its own oscillator frequency and phase registers.
// - both modes start acquiring only at a trigger, not on arming.
// - with locking in use, triggers are ignored until sync completes.
// - output is cut into packets of a programmed size, back to back.
`include "acqs_regs.svh"
module acqs_ctrl
	import acqs_pkg::*;
#(
	parameter int NCH = 4,
	parameter int FIFO_LOG2 = 6
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// External pins
	input wire logic trig_in,
	input wire logic sync_in,
	input wire logic ref_ext,
	// Sample stream from the down-converter chain, I and Q of one channel
	input wire logic smp_valid,
	input wire logic [15:0] smp_i,
	input wire logic [15:0] smp_q,
	// Oscillator controls
	output logic [NCH*32-1:0] nco_freq,
	output logic [NCH*32-1:0] nco_phase,
	output logic [NCH*5-1:0] decim_log2,
	output logic nco_align,
	output logic ref_sel_int,
	// Host link stream
	output logic host_valid,
	input wire logic host_ready,
	output logic [31:0] host_data,
	output logic host_hdr,
	output logic host_last
);
	localparam int REF_DIV = `ACQS_CLK_HZ / `ACQS_REF_HZ;
	localparam int REF_HALF = REF_DIV / 2;

	// Returns 1 when the address selects a given offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : hit

	//////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] trig_sy;
	logic [1:0] sync_sy;
	logic [1:0] ref_sy;
	logic trig_d;
	logic sync_d;
	logic ref_d;
	logic ref_now;
	logic int_ref;
	logic [7:0] int_ref_cnt;

	// Two flops per pin, then a delayed copy for edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_sy <= 2'h0;
			sync_sy <= 2'h0;
			ref_sy <= 2'h0;
			trig_d <= 1'b0;
			sync_d <= 1'b0;
			ref_d <= 1'b0;
		end else begin
			trig_sy <= {trig_sy[0], trig_in};
			sync_sy <= {sync_sy[0], sync_in};
			ref_sy <= {ref_sy[0], ref_ext};
			trig_d <= trig_sy[1];
			sync_d <= sync_sy[1];
			ref_d <= ref_now;
		end
	end

	// Internal 10 MHz reference from the sampling clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_ref_cnt <= 8'h00;
			int_ref <= 1'b0;
		end else begin
			// Full divide keeps the period exact even for an odd ratio
			int_ref_cnt <= (int_ref_cnt == 8'(REF_DIV - 1)) ? 8'h00 : int_ref_cnt + 8'h01;
			int_ref <= (int_ref_cnt < 8'(REF_HALF));
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Registers
	logic [6:0] ctrl;
	logic [31:0] rec_len;
	logic [31:0] pkt_len;
	logic [31:0] ts;
	logic [31:0] rec_num;
	logic [31:0] ovf_cnt;
	logic synced;
	logic wait_sync;
	acqs_state_t state;

	wire wr_en = psel && penable && pwrite;
	wire [7:0] nco_rel = paddr - `ACQS_OFF_NCO_BASE;
	wire nco_hit = (paddr >= `ACQS_OFF_NCO_BASE) &&
		(nco_rel < 8'(NCH * 8)) && (paddr[1:0] == 2'b00);
	wire [2:0] nco_ch = nco_rel[5:3];
	wire nco_is_ph = nco_rel[2];
	wire [2:0] dec_ch = paddr[4:2];
	wire mapped = hit(paddr, `ACQS_OFF_CTRL) || hit(paddr, `ACQS_OFF_STATUS) ||
		hit(paddr, `ACQS_OFF_RECLEN) || hit(paddr, `ACQS_OFF_PKTLEN) ||
		hit(paddr, `ACQS_OFF_DECIM) || hit(paddr, `ACQS_OFF_RECNUM) ||
		hit(paddr, `ACQS_OFF_TSLO) || hit(paddr, `ACQS_OFF_OVFCNT) || nco_hit;
	wire start_cmd = wr_en && hit(paddr, `ACQS_OFF_CTRL) && pwdata[`ACQS_CTRL_START];
	wire stop_cmd = wr_en && hit(paddr, `ACQS_OFF_CTRL) && pwdata[`ACQS_CTRL_STOP];
	wire arm_cmd = wr_en && hit(paddr, `ACQS_OFF_CTRL) && pwdata[`ACQS_CTRL_ARM_SYNC];

	// Strobe selection and edges
	assign ref_now = ctrl[`ACQS_CTRL_REF_INT] ? int_ref : ref_sy[1];
	wire ref_rise = ref_now && !ref_d;
	wire strobe_lvl = ctrl[`ACQS_CTRL_TRIG_AS_SYNC] ? trig_sy[1] : sync_sy[1];
	wire strobe_prev = ctrl[`ACQS_CTRL_TRIG_AS_SYNC] ? trig_d : sync_d;
	wire strobe_rise = strobe_lvl && !strobe_prev;
	logic strobe_seen;
	wire align_now = wait_sync && (strobe_seen || strobe_rise) && ref_rise;
	wire trig_rise = trig_sy[1] && !trig_d;
	// With the lock bit set, triggers blocked until sync done; the strobe trigger is not a start trigger
	wire trig_ok = trig_rise && (!ctrl[`ACQS_CTRL_LOCK] || synced) &&
		!(wait_sync && ctrl[`ACQS_CTRL_TRIG_AS_SYNC]);

	// Control, lengths, oscillator and decimation registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= 7'h00;
			rec_len <= `ACQS_RECLEN_RST;
			pkt_len <= `ACQS_PKTLEN_RST;
			nco_freq <= '0;
			nco_phase <= '0;
			decim_log2 <= '0;
		end else if (wr_en) begin
			if (hit(paddr, `ACQS_OFF_CTRL)) ctrl <= {pwdata[6:2], 2'b00};
			if (hit(paddr, `ACQS_OFF_RECLEN) && pwdata != 32'h0) rec_len <= pwdata;
			if (hit(paddr, `ACQS_OFF_PKTLEN) && pwdata != 32'h0) pkt_len <= pwdata;
			if (hit(paddr, `ACQS_OFF_DECIM)) begin // Channel 0 only
				decim_log2[dec_ch[1:0]*5 +: 5] <= pwdata[4:0];
			end
			if (nco_hit && !nco_is_ph) nco_freq[nco_ch*32 +: 32] <= pwdata;
			if (nco_hit && nco_is_ph) nco_phase[nco_ch*32 +: 32] <= pwdata;
		end
	end

	// Sync arming, alignment pulse and time-stamp
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_sync <= 1'b0;
			strobe_seen <= 1'b0;
			synced <= 1'b0;
			nco_align <= 1'b0;
			ts <= 32'h0;
		end else begin
			nco_align <= align_now;
			if (align_now) begin
				// A new arm in the same cycle wins over the clear
				wait_sync <= arm_cmd;
				strobe_seen <= 1'b0;
				synced <= !arm_cmd;
			end else begin
				if (arm_cmd) begin
					wait_sync <= 1'b1;
					synced <= 1'b0;
				end
				if (wait_sync && strobe_rise) strobe_seen <= 1'b1;
			end
			ts <= align_now ? 32'h0 : ts + 32'h1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Capture state machine
	logic [31:0] smp_cnt;
	logic [31:0] pkt_cnt;
	logic [31:0] trig_ts;
	acqs_word_t hdr_word;
	logic f_valid;
	logic f_ready;
	logic [31:0] f_data;
	logic f_hdr;
	logic f_full;
	wire triggered = ctrl[`ACQS_CTRL_TRIGD];
	wire take_smp = (state == ACQS_CAPTURE) && smp_valid;
	wire rec_end = triggered && take_smp && (smp_cnt == rec_len - 32'h1);

	// Buffer input: header words take precedence, samples packed I low, Q high
	assign f_valid = (state == ACQS_HEADER) || take_smp;
	assign f_hdr = (state == ACQS_HEADER);
	assign f_data = (hdr_word == ACQS_W_HDR_TS) ? trig_ts :
		(hdr_word == ACQS_W_HDR_NUM) ? rec_num : {smp_q, smp_i};

	// Sequencing of modes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ACQS_IDLE;
			smp_cnt <= 32'h0;
			rec_num <= 32'h0;
			trig_ts <= 32'h0;
			hdr_word <= ACQS_W_DATA;
			ovf_cnt <= 32'h0;
		end else begin
			if (take_smp && !f_ready) ovf_cnt <= ovf_cnt + 32'h1;
			if (align_now) rec_num <= 32'h0;
			unique case (state)
				ACQS_IDLE: begin
					if (start_cmd) begin
						state <= ACQS_WAIT_TRIG;
						rec_num <= 32'h0;
					end
				end
				ACQS_WAIT_TRIG: begin
					if (stop_cmd) begin
						state <= ACQS_IDLE;
					end else if (trig_ok) begin
						trig_ts <= ts;
						smp_cnt <= 32'h0;
						if (triggered) begin
							state <= ACQS_HEADER;
							hdr_word <= ACQS_W_HDR_TS;
						end else begin
							state <= ACQS_CAPTURE;
						end
					end
				end
				ACQS_HEADER: begin
					if (f_ready) begin
						if (hdr_word == ACQS_W_HDR_TS) begin
							hdr_word <= ACQS_W_HDR_NUM;
						end else begin
							hdr_word <= ACQS_W_DATA;
							state <= ACQS_CAPTURE;
						end
					end
				end
				ACQS_CAPTURE: begin
					if (take_smp) smp_cnt <= smp_cnt + 32'h1;
					if (rec_end) begin
						rec_num <= rec_num + 32'h1;
						state <= stop_cmd ? ACQS_IDLE : ACQS_WAIT_TRIG;
					end else if (stop_cmd) begin
						state <= ACQS_IDLE;
					end
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Buffer toward the host link
	logic b_valid;
	logic b_ready;
	logic [33:0] b_data;
	wire out_take = host_valid && host_ready;
	assign b_ready = !host_valid || host_ready;

	acqs_fifo #(
		.WIDTH(34),
		.DEPTH_LOG2(FIFO_LOG2)
	) u_buf (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(f_valid),
		.in_ready(f_ready),
		.in_data({f_hdr, 1'b0, f_data}),
		.out_valid(b_valid),
		.out_ready(b_ready),
		.out_data(b_data)
	);

	// Output register with packet framing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_valid <= 1'b0;
			host_data <= 32'h0;
			host_hdr <= 1'b0;
			host_last <= 1'b0;
			pkt_cnt <= 32'h0;
			f_full <= 1'b0;
		end else begin
			f_full <= !f_ready;
			if (b_ready) begin
				host_valid <= b_valid;
				host_data <= b_data[31:0];
				host_hdr <= b_data[33];
				host_last <= b_valid && (pkt_cnt == pkt_len - 32'h1);
				if (b_valid) begin
					pkt_cnt <= (pkt_cnt == pkt_len - 32'h1) ? 32'h0 : pkt_cnt + 32'h1;
				end
			end else if (out_take) begin
				host_valid <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// APB read path
	wire [31:0] status_w = {27'h0, f_full, state == ACQS_CAPTURE, synced, wait_sync,
		state != ACQS_IDLE};
	wire [31:0] rd_mux = hit(paddr, `ACQS_OFF_CTRL) ? {25'h0, ctrl} :
		hit(paddr, `ACQS_OFF_STATUS) ? status_w :
		hit(paddr, `ACQS_OFF_RECLEN) ? rec_len :
		hit(paddr, `ACQS_OFF_PKTLEN) ? pkt_len :
		hit(paddr, `ACQS_OFF_DECIM) ? {12'h0, decim_log2} :
		hit(paddr, `ACQS_OFF_RECNUM) ? rec_num :
		hit(paddr, `ACQS_OFF_TSLO) ? ts :
		hit(paddr, `ACQS_OFF_OVFCNT) ? ovf_cnt :
		(nco_hit && !nco_is_ph) ? nco_freq[nco_ch*32 +: 32] :
		nco_hit ? nco_phase[nco_ch*32 +: 32] : 32'h0;

	// Zero-wait answer, registered read data and error flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			ref_sel_int <= 1'b0;
		end else begin
			ref_sel_int <= ctrl[`ACQS_CTRL_REF_INT];
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (psel && !penable && !pwrite) prdata <= rd_mux;
		end
	end
endmodule : acqs_ctrl

//--- acqs_ctrl_props.sv
// Port checks of the acquisition control block
module acqs_ctrl_props #(
	parameter int NCH = 4
) (
	// Clock, reset and APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Reference and alignment
	input wire logic ref_ext,
	input wire logic ref_sel_int,
	input wire logic nco_align,
	// Host link
	input wire logic host_valid,
	input wire logic host_ready,
	input wire logic [31:0] host_data,
	input wire logic host_hdr,
	input wire logic host_last
);
	logic ref_q;
	logic [7:0] ref_age;
	logic [1:0] hdr_run;
	// Offsets that hold a register
	wire logic mapped = paddr < 8'h20 || (paddr >= 8'h40 && int'(paddr) < 64 + 8 * NCH);
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence take_s;
		host_valid && host_ready;
	endsequence
	////////////////////////////////
	// Age of the last reference rise; header words taken in a row
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_q <= 1'b0;
			ref_age <= 8'hff;
			hdr_run <= 2'h0;
		end else begin
			ref_q <= ref_ext;
			ref_age <= (ref_ext && !ref_q) ? 8'h00 : ref_age + {7'h0, ref_age != 8'hff};
			if (host_valid && host_ready) hdr_run <= host_hdr ? hdr_run + 2'h1 : 2'h0;
		end
	end
	////////////////////////////////
	// Bus answers, link holding, header pairing, alignment timing
	apb_answer_a: assert property (setup_s |=> pready ##1 !pready)
		else $error("apb answer late or long");
	ready_phase_a: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	err_decode_a: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == !mapped)
		else $error("wrong error response");
	err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read gave data");
	link_hold_a: assert property (host_valid && !host_ready |=> host_valid &&
		$stable(host_data) && $stable(host_hdr) && $stable(host_last))
		else $error("link word changed in stall");
	hdr_pair_a: assert property (take_s |-> (host_hdr ? hdr_run < 2'h2 : hdr_run != 2'h1))
		else $error("header words not paired");
	align_pulse_a: assert property (nco_align |=> !nco_align)
		else $error("align pulse too long");
	align_ref_a: assert property (nco_align && !ref_sel_int |-> ref_age <= 8'd8)
		else $error("align far from reference edge");
endmodule : acqs_ctrl_props
bind acqs_ctrl acqs_ctrl_props #(.NCH(NCH)) acqs_ctrl_props_i (.*);

//--- acqs_host_model.sv
// Host side model: takes link words, stalling on request
module acqs_host_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link from the block
	input wire logic host_valid,
	input wire logic [31:0] host_data,
	input wire logic host_hdr,
	input wire logic host_last,
	output logic host_ready,
	// Bench side: stall request and each taken word
	input wire logic slow,
	output logic got,
	output logic [33:0] got_word
);
	// Ready every cycle, or every other cycle when slow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_ready <= 1'b0;
			got <= 1'b0;
			got_word <= 34'h0;
		end else begin
			host_ready <= slow ? !host_ready : 1'b1;
			got <= host_valid && host_ready;
			got_word <= {host_hdr, host_last, host_data};
		end
	end
endmodule : acqs_host_model

//--- tb_top.sv
// Self-checking bench of the acquisition control block
`include "acqs_regs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] a; logic [31:0] v; logic e;} acqs_row_t;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic trig_in = 1'b0, sync_in = 1'b0, ref_ext = 1'b0, smp_valid = 1'b0, slow = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, host_data, rd;
	logic [15:0] smp_i = 16'h0;
	wire logic [15:0] smp_q = ~smp_i;
	logic pready, pslverr, er, nco_align, ref_sel_int, got;
	logic host_valid, host_ready, host_hdr, host_last;
	logic [127:0] nco_freq, nco_phase;
	logic [19:0] decim_log2;
	logic [33:0] got_word;
	logic [33:0] q[$];
	int fail_count = 0, cmp_count = 0, rc = 0, acnt = 0;
	acqs_row_t rows[7] = '{'{`ACQS_OFF_CTRL, 32'h0, 1'b0}, '{`ACQS_OFF_STATUS, 32'h0, 1'b0},
		'{`ACQS_OFF_RECLEN, `ACQS_RECLEN_RST, 1'b0}, '{`ACQS_OFF_PKTLEN, `ACQS_PKTLEN_RST, 1'b0},
		'{`ACQS_OFF_DECIM, `ACQS_DECIM_RST, 1'b0}, '{`ACQS_OFF_RECNUM, 32'h0, 1'b0},
		'{8'h30, 32'h0, 1'b1}};
	acqs_ctrl #(.NCH(4), .FIFO_LOG2(6)) acqs_ctrl_i (.*);
	acqs_host_model acqs_host_model_i (.*);
	////////////////////////////////
	// Compare, timeout and verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: %h not %h", $time, g, e);
		end
	endtask : chk
	task automatic summarize;
		if (fail_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize
	task automatic tmo;
		$display("unexpected at %0t: wait ran out", $time);
		fail_count++;
		summarize();
	endtask : tmo
	// APB transfer: setup, then access until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 40) tmo();
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] v);
		apb(1'b0, a, 32'h0);
		chk(rd, v);
	endtask : rdc
	// Pin pulses and bounded waits
	task automatic pin_pulse(input logic s);
		if (s) sync_in <= 1'b1;
		else trig_in <= 1'b1;
		repeat (4) @(posedge pclk);
		sync_in <= 1'b0;
		trig_in <= 1'b0;
		@(posedge pclk);
	endtask : pin_pulse
	task automatic wait_words(input int n);
		int k;
		for (k = 0; k < 400 && q.size() < n; k++) @(posedge pclk);
		if (q.size() < n) tmo();
	endtask : wait_words
	task automatic wait_align(input int n);
		int k;
		for (k = 0; k < 200 && acnt == n; k++) @(posedge pclk);
		if (acnt == n) tmo();
	endtask : wait_align
	////////////////////////////////
	// Clock; samples every other cycle; reference flips every 12 cycles
	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		smp_valid <= !smp_valid;
		if (smp_valid) smp_i <= smp_i + 16'h1;
		rc <= (rc == 11) ? 0 : rc + 1;
		if (rc == 11) ref_ext <= !ref_ext;
		if (got === 1'b1) q.push_back(got_word);
		if (nco_align === 1'b1) acnt <= acnt + 1;
	end
	////////////////////////////////
	// Main sequence
	initial begin
		int i, n;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 7; i++) begin
			rdc(rows[i].a, rows[i].v);
			chk({31'h0, er}, {31'h0, rows[i].e});
		end
		// Record setup, oscillators, decimation, reference choice
		wr(`ACQS_OFF_RECLEN, 32'h4);
		wr(`ACQS_OFF_RECLEN, 32'h0);
		rdc(`ACQS_OFF_RECLEN, 32'h4);
		wr(`ACQS_OFF_PKTLEN, 32'h3);
		wr(`ACQS_OFF_DECIM, 32'h3);
		wr(8'h48, 32'h1234_5678);
		wr(8'h54, 32'h0000_abcd);
		wr(`ACQS_OFF_CTRL, 32'h40);
		@(posedge pclk);
		chk({27'h0, decim_log2[4:0]}, 32'h3);
		chk(nco_freq[63:32], 32'h1234_5678);
		chk(nco_phase[95:64], 32'h0000_abcd);
		chk({31'h0, ref_sel_int}, 32'h1);
		// Two triggered records, the second with the host stalling
		wr(`ACQS_OFF_CTRL, 32'h5);
		repeat (30) @(posedge pclk);
		chk(32'(q.size()), 32'h0);
		pin_pulse(1'b0);
		wait_words(6);
		slow <= 1'b1;
		pin_pulse(1'b0);
		wait_words(12);
		repeat (60) @(posedge pclk);
		chk(32'(q.size()), 32'hc);
		for (i = 0; i < 12; i++) begin
			n = i % 6;
			chk({31'h0, q[i][33]}, {31'h0, n < 2});
			chk({31'h0, q[i][32]}, {31'h0, i % 3 == 2});
			if (n > 1) chk({q[i][31:16], 16'h0}, {~q[i][15:0], 16'h0});
			if (n > 2) chk({16'h0, q[i][15:0]}, {16'h0, q[i-1][15:0] + 16'h1});
		end
		chk(q[1][31:0], 32'h0);
		chk(q[7][31:0], 32'h1);
		rdc(`ACQS_OFF_OVFCNT, 32'h0);
		wr(`ACQS_OFF_CTRL, 32'h2);
		slow <= 1'b0;
		q.delete();
		// Lock in use: trigger ignored until the strobe aligns, then a gapless stream
		wr(`ACQS_OFF_CTRL, 32'h19);
		pin_pulse(1'b0);
		repeat (40) @(posedge pclk);
		chk(32'(q.size()), 32'h0);
		n = acnt;
		pin_pulse(1'b1);
		wait_align(n);
		rdc(`ACQS_OFF_RECNUM, 32'h0);
		rdc(`ACQS_OFF_STATUS, 32'h5);
		apb(1'b0, `ACQS_OFF_TSLO, 32'h0);
		chk({31'h0, rd < 32'h40}, 32'h1);
		pin_pulse(1'b0);
		wait_words(20);
		for (i = 1; i < 20; i++) begin
			chk({31'h0, q[i][33]}, 32'h0);
			chk({16'h0, q[i][15:0]}, {16'h0, q[i-1][15:0] + 16'h1});
		end
		wr(`ACQS_OFF_CTRL, 32'h2);
		// Trigger input acting as the strobe
		n = acnt;
		wr(`ACQS_OFF_CTRL, 32'h30);
		pin_pulse(1'b0);
		wait_align(n);
		// Reset in mid-stream
		wr(`ACQS_OFF_CTRL, 32'h1);
		pin_pulse(1'b0);
		repeat (10) @(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		chk({31'h0, host_valid}, 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(`ACQS_OFF_RECLEN, `ACQS_RECLEN_RST);
		summarize();
	end
endmodule : tb_top
